// File: hdl/oag_pkg.sv
// Constants and types for the operand address generator of an 8-bit core.
// Assumes a 16-bit byte address space shared by code and data.
// Functional notes
// - Register modes touch A, X, Y, carry or status word; no address formed.
// - Immediate mode uses the byte after the opcode as the operand directly.
// - With page flag set, data address is page register high, operand byte low.
// - Direct-page mode uses the operand byte as address inside the current page.
// - Absolute mode: first operand byte is address low, second is address high.
// - Three-byte absolute instructions reach the whole memory space.
// - Absolute read-modify-write uses full 16-bit address whatever the page flag.
// - X-indexed direct page without offset uses X as the page address.
// - X-indexed direct page with offset adds operand to X within the page.
// - Auto-increment (load/store A only) addresses page via X, then X plus one.
// - Y-indexed direct page adds operand to Y within the page.
// - Y-indexed absolute adds Y to the 16-bit operand, anywhere in memory.
// - Direct-page indirect jump/call fetches 16-bit target from page byte pair.
// - X-indexed indirect: pointer at page pair operand plus X, then access target.
// - Y-indexed indirect: pointer at page pair operand, plus Y, then access.
// - Absolute indirect jump loads PC from pointer at the absolute address.

`default_nettype none

package oag_pkg;

	localparam logic [7:0] page_reset = 8'h00;
	localparam logic [7:0] x_reset    = 8'h00;
	localparam logic [7:0] zero_page  = 8'h00;
	localparam logic [7:0] one_byte   = 8'h01;

	typedef enum logic [3:0]
	{
		am_register    = 4'h0,
		am_immediate   = 4'h1,
		am_direct      = 4'h2,
		am_absolute    = 4'h3,
		am_abs_rmw     = 4'h4,
		am_x_direct    = 4'h5,
		am_dp_x        = 4'h6,
		am_x_autoinc   = 4'h7,
		am_dp_y        = 4'h8,
		am_abs_y       = 4'h9,
		am_dp_ind_jump = 4'ha,
		am_dp_x_ind    = 4'hb,
		am_dp_ind_y    = 4'hc,
		am_abs_ind     = 4'hd
	} mode_t;

	typedef enum logic [4:0]
	{
		st_idle    = 5'b00001,
		st_ptr_lo  = 5'b00010,
		st_ptr_hi  = 5'b00100,
		st_final   = 5'b01000,
		st_done    = 5'b10000
	} state_t;

endpackage : oag_pkg

`default_nettype wire

// File: hdl/oag_sync.sv
// Two-stage synchroniser for the asynchronous active-low reset release.
// Assumes reset_n may deassert at any time relative to clk.

`default_nettype none

module oag_sync
(
	// Clock and raw reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Synchronised reset
	output logic      reset_sync_n
);

	typedef struct packed
	{
		logic stage1;
		logic stage2;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb
	begin
		s_d        = s_q;
		s_d.stage1 = 1'b1;
		s_d.stage2 = s_q.stage1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign reset_sync_n = s_q.stage2;

endmodule : oag_sync

`default_nettype wire

// File: hdl/oag_page_addr.sv
// Forms a direct-page address from a page byte and an 8-bit base plus index.
// Purely combinational; used by every direct-page style address path.

`default_nettype none

module oag_page_addr
(
	// Page selection
	input  wire logic        page_flag,
	input  wire logic [7:0]  page_reg,
	// Offset terms
	input  wire logic [7:0]  base,
	input  wire logic [7:0]  index,
	// Result
	output logic      [15:0] addr
);

	logic [7:0] low_sum;

	// The sum drops its carry so the index never leaves the page.
	assign low_sum = 8'(base + index);
	assign addr    = {page_flag ? page_reg : oag_pkg::zero_page, low_sum};

endmodule : oag_page_addr

`default_nettype wire

// File: hdl/operand_address_generator.sv
// Operand address generator: turns a decoded addressing mode and operand bytes into
// an effective data or jump address, fetching pointers for indirect modes.
// Assumes memory answers a read strobe with mem_rdata exactly one cycle later.

`default_nettype none

module operand_address_generator
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Request from the core
	input  wire logic         start,
	input  wire oag_pkg::mode_t mode,
	input  wire logic [7:0]   operand_lo,
	input  wire logic [7:0]   operand_hi,
	input  wire logic [7:0]   reg_y,
	input  wire logic         page_flag,
	// Index X load and page register write from the core
	input  wire logic         x_load,
	input  wire logic [7:0]   x_load_value,
	input  wire logic         ram_page_register_we,
	input  wire logic [7:0]   ram_page_register_wdata,
	// Memory read port for pointer fetch
	output logic              mem_rd,
	output logic [15:0]       mem_addr,
	input  wire logic [7:0]   mem_rdata,
	// Answer to the core
	output logic              busy,
	output logic              done,
	output logic [15:0]       eff_addr,
	output logic              addr_valid,
	output logic              jump,
	output logic [7:0]        imm_value,
	output logic              imm_valid,
	output logic [7:0]        reg_x,
	output logic [7:0]        ram_page_register
);

	typedef struct packed
	{
		oag_pkg::state_t state;
		oag_pkg::mode_t  mode;
		logic [7:0]      op_lo;
		logic [7:0]      op_hi;
		logic [7:0]      y;
		logic            pflag;
		logic [7:0]      ptr_lo;
		logic [15:0]     ptr_addr;
		logic            rd;
		logic [15:0]     rd_addr;
		logic [15:0]     eff;
		logic            valid;
		logic            jmp;
		logic [7:0]      imm;
		logic            immv;
		logic            done;
		logic [7:0]      x;
		logic [7:0]      page;
	} core_state_t;

	core_state_t s_q;
	core_state_t s_d;
	logic        rst_n;

	logic [15:0] dp_plain;
	logic [15:0] dp_x_off;
	logic [15:0] dp_x_only;
	logic [15:0] dp_y_off;
	logic [15:0] in_dp_plain;
	logic [15:0] in_dp_x_off;

	oag_sync u_sync
	(
		.clk          (clk),
		.reset_n      (reset_n),
		.reset_sync_n (rst_n)
	);

	// Request-time paths use the live inputs; pointer paths reuse latched copies.
	oag_page_addr u_dp
	(
		.page_flag (page_flag),
		.page_reg  (s_q.page),
		.base      (operand_lo),
		.index     (8'h00),
		.addr      (dp_plain)
	);

	oag_page_addr u_dpx
	(
		.page_flag (page_flag),
		.page_reg  (s_q.page),
		.base      (operand_lo),
		.index     (s_q.x),
		.addr      (dp_x_off)
	);

	oag_page_addr u_x
	(
		.page_flag (page_flag),
		.page_reg  (s_q.page),
		.base      (s_q.x),
		.index     (8'h00),
		.addr      (dp_x_only)
	);

	oag_page_addr u_dpy
	(
		.page_flag (page_flag),
		.page_reg  (s_q.page),
		.base      (operand_lo),
		.index     (reg_y),
		.addr      (dp_y_off)
	);

	// The next byte of a page pointer stays in the same page.
	oag_page_addr u_ptr_next
	(
		.page_flag (s_q.pflag),
		.page_reg  (s_q.page),
		.base      (s_q.ptr_addr[7:0]),
		.index     (oag_pkg::one_byte),
		.addr      (in_dp_plain)
	);

	assign in_dp_x_off = 16'(s_q.ptr_addr + 16'h0001);

	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		s_d.rd   = 1'b0;
		if (ram_page_register_we)
		begin
			s_d.page = ram_page_register_wdata;
		end
		if (x_load)
		begin
			s_d.x = x_load_value;
		end
		case (s_q.state)
			oag_pkg::st_idle:
			begin
				if (start)
				begin
					s_d.mode  = mode;
					s_d.op_lo = operand_lo;
					s_d.op_hi = operand_hi;
					s_d.y     = reg_y;
					s_d.pflag = page_flag;
					s_d.valid = 1'b0;
					s_d.immv  = 1'b0;
					s_d.jmp   = 1'b0;
					s_d.state = oag_pkg::st_done;
					case (mode)
						oag_pkg::am_register:
						begin
							s_d.eff = 16'h0000;
						end
						oag_pkg::am_immediate:
						begin
							s_d.imm  = operand_lo;
							s_d.immv = 1'b1;
						end
						oag_pkg::am_direct:
						begin
							s_d.eff   = dp_plain;
							s_d.valid = 1'b1;
						end
						oag_pkg::am_absolute, oag_pkg::am_abs_rmw:
						begin
							// Full 16 bits: the page flag plays no part here.
							s_d.eff   = {operand_hi, operand_lo};
							s_d.valid = 1'b1;
						end
						oag_pkg::am_x_direct:
						begin
							s_d.eff   = dp_x_only;
							s_d.valid = 1'b1;
						end
						oag_pkg::am_dp_x:
						begin
							s_d.eff   = dp_x_off;
							s_d.valid = 1'b1;
						end
						oag_pkg::am_x_autoinc:
						begin
							s_d.eff   = dp_x_only;
							s_d.valid = 1'b1;
							s_d.x     = 8'(s_q.x + oag_pkg::one_byte);
						end
						oag_pkg::am_dp_y:
						begin
							s_d.eff   = dp_y_off;
							s_d.valid = 1'b1;
						end
						oag_pkg::am_abs_y:
						begin
							s_d.eff   = 16'({operand_hi, operand_lo} + {8'h00, reg_y});
							s_d.valid = 1'b1;
						end
						oag_pkg::am_dp_ind_jump, oag_pkg::am_dp_ind_y:
						begin
							s_d.ptr_addr = dp_plain;
							s_d.state    = oag_pkg::st_ptr_lo;
						end
						oag_pkg::am_dp_x_ind:
						begin
							s_d.ptr_addr = dp_x_off;
							s_d.state    = oag_pkg::st_ptr_lo;
						end
						oag_pkg::am_abs_ind:
						begin
							s_d.ptr_addr = {operand_hi, operand_lo};
							s_d.state    = oag_pkg::st_ptr_lo;
						end
						default:
						begin
							s_d.state = oag_pkg::st_done;
						end
					endcase
					if (s_d.state == oag_pkg::st_ptr_lo)
					begin
						s_d.rd      = 1'b1;
						s_d.rd_addr = s_d.ptr_addr;
					end
				end
			end
			oag_pkg::st_ptr_lo:
			begin
				// Low byte read is on the bus now and returns in st_ptr_hi; ask for the high byte at the next address.
				s_d.rd    = 1'b1;
				s_d.state = oag_pkg::st_ptr_hi;
				if (s_q.mode == oag_pkg::am_abs_ind)
				begin
					s_d.rd_addr = in_dp_x_off;
				end
				else
				begin
					s_d.rd_addr = in_dp_plain;
				end
			end
			oag_pkg::st_ptr_hi:
			begin
				s_d.ptr_lo = mem_rdata;
				s_d.state  = oag_pkg::st_final;
			end
			oag_pkg::st_final:
			begin
				s_d.valid = 1'b1;
				s_d.state = oag_pkg::st_done;
				if (s_q.mode == oag_pkg::am_dp_ind_y)
				begin
					s_d.eff = 16'({mem_rdata, s_q.ptr_lo} + {8'h00, s_q.y});
				end
				else
				begin
					s_d.eff = {mem_rdata, s_q.ptr_lo};
				end
				s_d.jmp = (s_q.mode == oag_pkg::am_dp_ind_jump) ||
				          (s_q.mode == oag_pkg::am_abs_ind);
			end
			oag_pkg::st_done:
			begin
				s_d.done  = 1'b1;
				s_d.state = oag_pkg::st_idle;
			end
			default:
			begin
				s_d.state = oag_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q       <= '0;
			s_q.state <= oag_pkg::st_idle;
			s_q.mode  <= oag_pkg::am_register;
			s_q.x     <= oag_pkg::x_reset;
			s_q.page  <= oag_pkg::page_reset;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign mem_rd            = s_q.rd;
	assign mem_addr          = s_q.rd_addr;
	assign busy              = (s_q.state != oag_pkg::st_idle);
	assign done              = s_q.done;
	assign eff_addr          = s_q.eff;
	assign addr_valid        = s_q.valid;
	assign jump              = s_q.jmp;
	assign imm_value         = s_q.imm;
	assign imm_valid         = s_q.immv;
	assign reg_x             = s_q.x;
	assign ram_page_register = s_q.page;

endmodule : operand_address_generator

`default_nettype wire

// File: sim/oag_chk_properties.sv
// Concurrent checks on the ports of the operand address generator.
// Assumes the bench keeps page and X writes apart from requests.
`default_nettype none
module oag_chk
(
	// Clock, reset and request
	input wire logic           clk,
	input wire logic           reset_n,
	input wire logic           start,
	input wire oag_pkg::mode_t mode,
	input wire logic [7:0]     operand_lo,
	input wire logic [7:0]     operand_hi,
	input wire logic [7:0]     reg_y,
	input wire logic           page_flag,
	// Answer
	input wire logic           mem_rd,
	input wire logic [15:0]    mem_addr,
	input wire logic           busy,
	input wire logic           done,
	input wire logic [15:0]    eff_addr,
	input wire logic           addr_valid,
	input wire logic [7:0]     reg_x,
	input wire logic [7:0]     ram_page_register
);
	logic tk;
	logic ind;
	assign tk = start & ~busy;
	assign ind = mode inside {oag_pkg::am_dp_ind_jump, oag_pkg::am_dp_x_ind,
		oag_pkg::am_dp_ind_y, oag_pkg::am_abs_ind};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	chk_dp_zero: assert property (
		tk && mode == oag_pkg::am_direct && !page_flag
		|=> eff_addr == {8'h00, $past(operand_lo)} && addr_valid)
		else $error("direct page address wrong with page flag clear");
	chk_dp_paged: assert property (
		tk && mode == oag_pkg::am_direct && page_flag
		|=> eff_addr == {$past(ram_page_register), $past(operand_lo)})
		else $error("paged direct address wrong");
	chk_abs_full: assert property (
		tk && (mode == oag_pkg::am_absolute || mode == oag_pkg::am_abs_rmw)
		|=> eff_addr == {$past(operand_hi), $past(operand_lo)})
		else $error("absolute address wrong");
	chk_abs_y: assert property (
		tk && mode == oag_pkg::am_abs_y
		|=> eff_addr == {$past(operand_hi), $past(operand_lo)} + {8'h00, $past(reg_y)})
		else $error("absolute plus Y address wrong");
	chk_dp_x_wrap: assert property (
		tk && mode == oag_pkg::am_dp_x && !page_flag
		|=> eff_addr == {8'h00, $past(operand_lo) + $past(reg_x)})
		else $error("page plus X address wrong");
	chk_x_autoinc: assert property (
		tk && mode == oag_pkg::am_x_autoinc
		|=> reg_x == $past(reg_x) + 8'h01 && eff_addr[7:0] == $past(reg_x))
		else $error("auto increment of X wrong");
	chk_reg_noaddr: assert property (
		tk && (mode == oag_pkg::am_register || mode == oag_pkg::am_immediate)
		|=> !addr_valid && eff_addr == 16'h0000 && !mem_rd ##1 done && !mem_rd)
		else $error("register or immediate mode formed an address");
	chk_ptr_pair: assert property (
		tk && ind |=> mem_rd ##1 mem_rd && mem_addr[7:0] == $past(mem_addr[7:0]) + 8'h01
		##1 !mem_rd)
		else $error("pointer byte pair reads wrong");
	chk_ind_done: assert property (
		tk && ind |=> !done [*4] ##1 done)
		else $error("indirect answer not on time");
	chk_ptr_zero: assert property (
		tk && mode == oag_pkg::am_dp_ind_jump && !page_flag
		|=> mem_addr == {8'h00, $past(operand_lo)})
		else $error("page pointer address wrong");
endmodule : oag_chk
bind operand_address_generator oag_chk u_chk (.clk, .reset_n, .start, .mode, .operand_lo,
	.operand_hi, .reg_y, .page_flag, .mem_rd, .mem_addr, .busy, .done, .eff_addr,
	.addr_valid, .reg_x, .ram_page_register);
`default_nettype wire

// File: sim/oag_mem.sv
// Behavioural memory answering pointer reads of the address generator.
// Assumes a read strobe wants its byte on the following cycle.
`default_nettype none
module oag_mem
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Read port
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output var  logic [7:0]  mem_rdata
);
	// Outside a read the bus toggles, so a late sample cannot match by chance.
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			mem_rdata <= 8'h00;
		else if (mem_rd)
			mem_rdata <= mem_addr[7:0] ^ {mem_addr[14:8], mem_addr[15]} ^ 8'h3c;
		else
			mem_rdata <= ~mem_rdata;
endmodule : oag_mem
`default_nettype wire

// File: sim/tb_operand_address_generator.sv
// Self-checking bench for the operand address generator.
// Assumes the memory model answers one cycle after each read strobe.
`default_nettype none
module tb_operand_address_generator;
	timeunit 1ns;
	timeprecision 100ps;
	logic           clk = 1'b0;
	logic           reset_n = 1'b0;
	logic           start = 1'b0;
	oag_pkg::mode_t mode = oag_pkg::am_register;
	logic [7:0]     operand_lo = 8'h00;
	logic [7:0]     operand_hi = 8'h00;
	logic [7:0]     reg_y = 8'h00;
	logic           page_flag = 1'b0;
	logic           x_load = 1'b0;
	logic [7:0]     x_load_value = 8'h00;
	logic           ram_page_register_we = 1'b0;
	logic [7:0]     ram_page_register_wdata = 8'h00;
	logic           mem_rd, busy, done, addr_valid, jump, imm_valid;
	logic [15:0]    mem_addr, eff_addr;
	logic [7:0]     mem_rdata, imm_value, reg_x, ram_page_register;
	logic [7:0]     s = 8'h47;
	logic [7:0]     tx, tp;
	logic           tg;
	logic [34:0]    q[$];
	int             error_cnt = 0;
	int             n_compared = 0;
	operand_address_generator uut (.clk, .reset_n, .start, .mode, .operand_lo, .operand_hi,
		.reg_y, .page_flag, .x_load, .x_load_value, .ram_page_register_we,
		.ram_page_register_wdata, .mem_rd, .mem_addr, .mem_rdata, .busy, .done, .eff_addr,
		.addr_valid, .jump, .imm_value, .imm_valid, .reg_x, .ram_page_register);
	oag_mem u_mem (.clk, .reset_n, .mem_rd, .mem_addr, .mem_rdata);
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		s = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
		return s;
	endfunction : rnd
	function automatic logic [7:0] mv(input logic [15:0] a);
		return a[7:0] ^ {a[14:8], a[15]} ^ 8'h3c;
	endfunction : mv
	function automatic logic [15:0] dp(input logic [7:0] a);
		return {tg ? tp : 8'h00, a};
	endfunction : dp
	function automatic logic [15:0] pd(input logic [7:0] a);
		return {mv(dp(a + 8'h01)), mv(dp(a))};
	endfunction : pd
	task automatic cmp(input string what, input logic [34:0] e, input logic [34:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	task automatic close_out();
		if (q.size() != 0)
			error_cnt++;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic setup();
		tx = rnd();
		tp = rnd();
		x_load <= 1'b1;
		x_load_value <= tx;
		ram_page_register_we <= 1'b1;
		ram_page_register_wdata <= tp;
		@(posedge clk);
		x_load <= 1'b0;
		ram_page_register_we <= 1'b0;
		repeat (2) @(posedge clk);
		cmp("x and page", {19'h0, tp, tx}, {19'h0, ram_page_register, reg_x});
	endtask : setup
	// Holding start a second cycle checks that a busy block ignores it.
	task automatic op(input logic [3:0] m, input int hold);
		logic [7:0]  lo, hi, y;
		logic [15:0] ab, e;
		int          n;
		lo = rnd();
		hi = rnd();
		y = rnd();
		tg = s[0];
		ab = {hi, lo};
		case (oag_pkg::mode_t'(m))
			oag_pkg::am_register, oag_pkg::am_immediate: e = 16'h0000;
			oag_pkg::am_direct: e = dp(lo);
			oag_pkg::am_x_direct, oag_pkg::am_x_autoinc: e = dp(tx);
			oag_pkg::am_dp_x: e = dp(lo + tx);
			oag_pkg::am_dp_y: e = dp(lo + y);
			oag_pkg::am_abs_y: e = ab + {8'h00, y};
			oag_pkg::am_dp_ind_jump: e = pd(lo);
			oag_pkg::am_dp_ind_y: e = pd(lo) + {8'h00, y};
			oag_pkg::am_dp_x_ind: e = pd(lo + tx);
			oag_pkg::am_abs_ind: e = {mv(ab + 16'h0001), mv(ab)};
			default: e = ab;
		endcase
		if (m == 4'h7)
			tx = tx + 8'h01;
		q.push_back({e, m > 4'h1, m == 4'ha || m == 4'hd, m == 4'h1, m == 4'h1 ? lo : 8'h00, tx});
		start <= 1'b1;
		mode <= oag_pkg::mode_t'(m);
		operand_lo <= lo;
		operand_hi <= hi;
		reg_y <= y;
		page_flag <= tg;
		repeat (hold) @(posedge clk);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 12)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 12)
			error_cnt++;
	endtask : op
	always @(posedge clk)
	begin
		if (done === 1'b1)
		begin
			if (q.size() == 0)
				cmp("unasked done", 35'h0, 35'h1);
			else
				cmp("result", q.pop_front(), {eff_addr, addr_valid, jump, imm_valid,
					imm_valid ? imm_value : 8'h00, reg_x});
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int r = 0; r < 6; r++)
		begin
			setup();
			for (int m = 0; m < 14; m++)
				op(4'(m), r == 1 ? 2 : 1);
			$display("round %0d ended", r);
		end
		repeat (4) @(posedge clk);
		close_out();
	end
	initial
	begin
		#20000;
		error_cnt++;
		close_out();
	end
endmodule : tb_operand_address_generator
`default_nettype wire
